// ---- shared/sdpc_pkg.sv ----
package sdpc_pkg;

    // ****************************************
    // operating modes carried in each frame
    // ****************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PD_1K  = 2'h1,
        MODE_PD_100K = 2'h2,
        MODE_PD_OPEN = 2'h3
    } sdpc_mode_t;

    typedef enum logic [2:0] {
        ST_RUN  = 3'h1,
        ST_DOWN = 3'h2,
        ST_WAKE = 3'h4
    } sdpc_state_t;

    // ****************************************
    // link side state
    // ****************************************
    typedef struct packed {
        logic [4:0]  cnt;
        logic [23:0] sh;
    } sdpc_shf_t;

    typedef struct packed {
        logic [23:0] word;
        logic        tgl;
    } sdpc_cap_t;

    // ****************************************
    // core side state
    // ****************************************
    typedef struct packed {
        logic [2:0]  tsync;
        logic        seen;
        logic [15:0] code;
        sdpc_mode_t  mode;
        sdpc_state_t st;
        logic [15:0] wake_cnt;
        logic [15:0] wake_len;
        logic        valid;
        logic [15:0] frames;
        logic        en;
        logic        amp_conn;
        logic        term_1k;
        logic        term_100k;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sdpc_core_t;

endpackage

// ---- shared/sdpc_regs.svh ----
`ifndef SDPC_REGS_SVH
`define SDPC_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SDPC_OFS_STATUS   12'h000
`define SDPC_OFS_CODE     12'h004
`define SDPC_OFS_RECOVER  12'h008

// ****************************************
// field positions
// ****************************************
`define SDPC_ST_MODE_LO   0
`define SDPC_ST_VALID     2
`define SDPC_ST_AMP_EN    3
`define SDPC_ST_WAKE      4
`define SDPC_ST_CNT_LO    16
`define SDPC_MODE_LO_24B  16
`define SDPC_MODE_LO_16B  14

// ****************************************
// reset values
// ****************************************
`define SDPC_CODE_ZERO    16'h0000
`define SDPC_CODE_MID     16'h8000

// ****************************************
// timing
// ****************************************
`define SDPC_CLK_NS       10
`define SDPC_WAKE_NS      5000
`define SDPC_WAKE_CYC     ((`SDPC_WAKE_NS + `SDPC_CLK_NS - 1) / `SDPC_CLK_NS)

`endif

// ---- tb/sdpc_host_model.sv ----
`timescale 1ns/10ps
// ****************************************
// host serial master, clock parked low
// ****************************************
module sdpc_host_model (
    output logic sclk_out,
    output logic sync_n_out,
    output logic din_out
);
    // idle state: no link clock outside frames
    initial begin
        sclk_out   = 1'b0;
        sync_n_out = 1'b1;
        din_out    = 1'b0;
    end
    // n bits msb first; fewer than 24 aborts the frame
    task automatic send(input logic [23:0] f, input int n);
        sync_n_out = 1'b0;
        #32;
        for (int k = 0; k < n; k++) begin
            if (k % 8 == 0 && k > 0) #64;
            sclk_out = 1'b1;
            din_out  = f[23-k];
            #32;
            sclk_out = 1'b0;
            #32;
        end
        sync_n_out = 1'b1;
        din_out    = ~din_out; // released line must not keep last bit
        #100;
    endtask
endmodule

// ---- tb/sdpc_top_properties.sv ----
`timescale 1ns/10ps
// ****************************************
// port level checks of the dac control
// ****************************************
module sdpc_top_properties (
    input wire logic        MCLK_IN,
    input wire logic        RST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic [15:0] DAC_CODE_OUT,
    input wire logic [1:0]  MODE_OUT,
    input wire logic        AMP_CONN_OUT,
    input wire logic        TERM_1K_OUT,
    input wire logic        TERM_100K_OUT,
    input wire logic        BIAS_EN_OUT,
    input wire logic        REF_EN_OUT,
    input wire logic        STRING_EN_OUT,
    input wire logic        AMP_EN_OUT,
    input wire logic        OUT_VALID_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    property p_amp; AMP_CONN_OUT == (MODE_OUT == 2'h0); endproperty
    a_amp: assert property (p_amp) else $error("amp link");
    property p_t1k; TERM_1K_OUT == (MODE_OUT == 2'h1); endproperty
    a_t1k: assert property (p_t1k) else $error("1k select");
    property p_t100k; TERM_100K_OUT == (MODE_OUT == 2'h2); endproperty
    a_t100k: assert property (p_t100k) else $error("100k select");
    property p_en;
        {BIAS_EN_OUT, REF_EN_OUT, STRING_EN_OUT, AMP_EN_OUT}
            == {4{MODE_OUT == 2'h0}};
    endproperty
    a_en: assert property (p_en) else $error("enables");
    property p_keep; (MODE_OUT != 2'h0) |-> $stable(DAC_CODE_OUT); endproperty
    a_keep: assert property (p_keep) else $error("code moved");
    property p_vdn; (MODE_OUT != 2'h0) [*2] |-> !OUT_VALID_OUT; endproperty
    a_vdn: assert property (p_vdn) else $error("valid in down");
    property p_wake; $rose(MODE_OUT == 2'h0) |-> !OUT_VALID_OUT; endproperty
    a_wake: assert property (p_wake) else $error("valid early");
    // bus answer comes in the first access cycle
    property p_ans; (PSEL_IN && !PENABLE_IN) |=> PREADY_OUT; endproperty
    a_ans: assert property (p_ans) else $error("no ready");
    property p_err; PSLVERR_OUT |-> PREADY_OUT && PSEL_IN; endproperty
    a_err: assert property (p_err) else $error("stray error");
endmodule
bind sdpc_top sdpc_top_properties u_props (.MCLK_IN(MCLK_IN),
    .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .DAC_CODE_OUT(DAC_CODE_OUT), .MODE_OUT(MODE_OUT),
    .AMP_CONN_OUT(AMP_CONN_OUT), .TERM_1K_OUT(TERM_1K_OUT),
    .TERM_100K_OUT(TERM_100K_OUT), .BIAS_EN_OUT(BIAS_EN_OUT),
    .REF_EN_OUT(REF_EN_OUT), .STRING_EN_OUT(STRING_EN_OUT),
    .AMP_EN_OUT(AMP_EN_OUT), .OUT_VALID_OUT(OUT_VALID_OUT));

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`include "sdpc_regs.svh"
module tb;
    typedef struct packed {
        logic [23:0] f;
        logic [1:0]  m;
        logic [15:0] c;
        logic        v;
    } sdpc_row_t;
    // ****************************************
    // frames and the outputs they should give
    // ****************************************
    localparam sdpc_row_t RST_ROW =
        '{24'h0, sdpc_pkg::MODE_NORMAL, `SDPC_CODE_ZERO, 1'b1};
    localparam sdpc_row_t ROWS [5] = '{
        '{24'hFC1234, sdpc_pkg::MODE_NORMAL,  16'h1234, 1'b1},
        '{24'h01ABCD, sdpc_pkg::MODE_PD_1K,   16'h1234, 1'b0},
        '{24'h020000, sdpc_pkg::MODE_PD_100K, 16'h1234, 1'b0},
        '{24'h03FFFF, sdpc_pkg::MODE_PD_OPEN, 16'h1234, 1'b0},
        '{24'h00BEEF, sdpc_pkg::MODE_NORMAL,  16'hBEEF, 1'b0}};
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] code;
    logic [1:0]  mode;
    logic        amp_conn, t1k, t100k, bias, refe, strg, ampe, valid;
    wire         sclk, sync_n, din;
    int          bad_count, checks_done, cyc;

    sdpc_top dut (.MCLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk),
        .SYNC_N_IN(sync_n), .DIN_IN(din), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .DAC_CODE_OUT(code), .MODE_OUT(mode),
        .AMP_CONN_OUT(amp_conn), .TERM_1K_OUT(t1k), .TERM_100K_OUT(t100k),
        .BIAS_EN_OUT(bias), .REF_EN_OUT(refe), .STRING_EN_OUT(strg),
        .AMP_EN_OUT(ampe), .OUT_VALID_OUT(valid));
    sdpc_host_model host (.sclk_out(sclk), .sync_n_out(sync_n),
        .din_out(din));

    // core clock, 10 ns
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard: whole run is well under 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            close_out;
        end
    end
    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", name, e, g);
        end
    endtask
    // apb master: hold request until ready seen at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no own limit: only the cycle guard above ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task outs(input sdpc_row_t r);
        logic n;
        n = (r.m == 2'h0);
        chk("mode", {30'h0, r.m}, {30'h0, mode});
        chk("code", {16'h0, r.c}, {16'h0, code});
        chk("enables", {25'h0, n, r.m == 2'h1, r.m == 2'h2, {4{n}}},
            {25'h0, amp_conn, t1k, t100k, bias, refe, strg, ampe});
        chk("valid", {31'h0, r.v}, {31'h0, valid});
    endtask
    task close_out;
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr  = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        outs(RST_ROW);
        apb(1'b1, `SDPC_OFS_RECOVER, 32'h28);
        apb(1'b0, `SDPC_OFS_RECOVER, 32'h0);
        chk("recover", 32'h28, rdata);
        chk("mapped_err", 32'h0, {31'h0, err});
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        host.send(24'h00ABCD, 10);
        repeat (8) @(posedge clk);
        outs(RST_ROW);
        foreach (ROWS[i]) begin
            host.send(ROWS[i].f, 24);
            repeat (8) @(posedge clk);
            outs(ROWS[i]);
        end
        repeat (45) @(posedge clk);
        chk("wake", 32'h1, {31'h0, valid});
        apb(1'b0, `SDPC_OFS_STATUS, 32'h0);
        chk("status", 32'h0005000C, rdata);
        apb(1'b0, `SDPC_OFS_CODE, 32'h0);
        chk("code_reg", 32'h0000BEEF, rdata);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        outs(RST_ROW);
        close_out;
    end
endmodule

// ---- verilog/sdpc_shift.sv ----
`timescale 1ns/10ps
`include "sdpc_regs.svh"

module sdpc_shift #(
    parameter int FRAME_BITS = 24
) (
    input  wire logic        rst_in,
    input  wire logic        sclk_in,
    input  wire logic        sync_n_in,
    input  wire logic        din_in,
    output logic [23:0]      word_out,
    output logic             tgl_out
);

    sdpc_pkg::sdpc_shf_t shf_r;
    sdpc_pkg::sdpc_shf_t shf_nxt;
    sdpc_pkg::sdpc_cap_t cap_r;
    sdpc_pkg::sdpc_cap_t cap_nxt;

    localparam logic [4:0] LAST = 5'(FRAME_BITS - 1);
    localparam logic [4:0] DONE = 5'(FRAME_BITS);

    // ****************************************
    // shift on falling edges inside a frame
    // ****************************************
    // msb enters first and walks upward
    always_comb begin
        shf_nxt = shf_r;
        cap_nxt = cap_r;
        if (shf_r.cnt != DONE) begin
            shf_nxt.sh  = {shf_r.sh[22:0], din_in};
            shf_nxt.cnt = shf_r.cnt + 5'h01;
        end
        if (shf_r.cnt == LAST) begin
            cap_nxt.word = {shf_r.sh[22:0], din_in};
            cap_nxt.tgl  = ~cap_r.tgl;
        end
    end

    // frame select high clears the shifter, since the link clock
    // may stop before the frame ends
    always_ff @(negedge sclk_in or posedge rst_in or posedge sync_n_in)
    begin
        if (rst_in || sync_n_in) begin
            shf_r <= '0;
        end else begin
            shf_r <= shf_nxt;
        end
    end

    // captured word survives aborts, only power-on clears it
    always_ff @(negedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            cap_r <= '0;
        end else begin
            cap_r <= cap_nxt;
        end
    end

    assign word_out = cap_r.word;
    assign tgl_out  = cap_r.tgl;

endmodule

// ---- verilog/sdpc_top.sv ----
`timescale 1ns/10ps
`include "sdpc_regs.svh"

module sdpc_top #(
    parameter bit MIDSCALE_RESET = 1'b0,
    parameter int FRAME_BITS     = 24,
    parameter int DATA_BITS      = 16
) (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        SCLK_IN,
    input  wire logic        SYNC_N_IN,
    input  wire logic        DIN_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic [15:0]      DAC_CODE_OUT,
    output logic [1:0]       MODE_OUT,
    output logic             AMP_CONN_OUT,
    output logic             TERM_1K_OUT,
    output logic             TERM_100K_OUT,
    output logic             BIAS_EN_OUT,
    output logic             REF_EN_OUT,
    output logic             STRING_EN_OUT,
    output logic             AMP_EN_OUT,
    output logic             OUT_VALID_OUT
);

    // ****************************************
    // constants
    // ****************************************
    localparam logic [15:0] CODE_RST =
        MIDSCALE_RESET ? `SDPC_CODE_MID : `SDPC_CODE_ZERO;
    localparam int MODE_LO = (FRAME_BITS == 24) ?
        `SDPC_MODE_LO_24B : `SDPC_MODE_LO_16B;
    localparam logic [15:0] WAKE_RST = 16'(`SDPC_WAKE_CYC);

    // ****************************************
    // functions
    // ****************************************
    // any non-zero mode is one of the power-down modes
    function automatic logic is_down(input logic [1:0] m);
        is_down = (m != 2'h0);
    endfunction

    // register index of an address, 2'h3 when unmapped
    function automatic logic [1:0] reg_sel(input logic [11:0] a);
        case (a)
            `SDPC_OFS_STATUS: begin
                reg_sel = 2'h0;
            end
            `SDPC_OFS_CODE: begin
                reg_sel = 2'h1;
            end
            `SDPC_OFS_RECOVER: begin
                reg_sel = 2'h2;
            end
            default: begin
                reg_sel = 2'h3;
            end
        endcase
    endfunction

    // ****************************************
    // link side receiver
    // ****************************************
    logic [23:0] link_word;
    logic        link_tgl;

    sdpc_shift #(
        .FRAME_BITS (FRAME_BITS)
    ) u_shift (
        .rst_in    (RST_IN),
        .sclk_in   (SCLK_IN),
        .sync_n_in (SYNC_N_IN),
        .din_in    (DIN_IN),
        .word_out  (link_word),
        .tgl_out   (link_tgl)
    );

    // ****************************************
    // state
    // ****************************************
    sdpc_pkg::sdpc_core_t core_r;
    sdpc_pkg::sdpc_core_t core_nxt;

    logic        frame_evt;
    logic [1:0]  frame_mode;
    logic [15:0] frame_code;
    logic [1:0]  sel;
    logic        setup;
    logic [31:0] status;

    // event counts once the last two stages agree on a new level
    assign frame_evt = (core_r.tsync[1] == core_r.tsync[2]) &&
                       (core_r.tsync[2] != core_r.seen);

    // mode field sits above the code bits in both frame sizes
    assign frame_mode = link_word[MODE_LO +: 2];
    assign frame_code = 16'(link_word[MODE_LO-1 -: DATA_BITS]);

    assign sel   = reg_sel(PADDR_IN);
    assign setup = PSEL_IN && !PENABLE_IN;

    // status word assembled from live state
    always_comb begin
        status = 32'h0000_0000;
        status[`SDPC_ST_MODE_LO +: 2] = core_r.mode;
        status[`SDPC_ST_VALID]        = core_r.valid;
        status[`SDPC_ST_AMP_EN]       = core_r.en;
        status[`SDPC_ST_WAKE]         =
            (core_r.st == sdpc_pkg::ST_WAKE);
        status[`SDPC_ST_CNT_LO +: 16] = core_r.frames;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        core_nxt = core_r;

        // toggle crossing; link word is stable for a whole frame
        core_nxt.tsync = {core_r.tsync[1:0], link_tgl};

        // frame takes effect only once fully received
        if (frame_evt) begin
            core_nxt.seen   = core_r.tsync[2];
            core_nxt.frames = core_r.frames + 16'h0001;
            core_nxt.mode   = sdpc_pkg::sdpc_mode_t'(frame_mode);
            if (!is_down(frame_mode)) begin
                core_nxt.code = frame_code;
            end
            // a power-down frame leaves the stored code alone
        end

        // wake sequencing
        case (core_r.st)
            sdpc_pkg::ST_RUN: begin
                if (frame_evt && is_down(frame_mode)) begin
                    core_nxt.st    = sdpc_pkg::ST_DOWN;
                    core_nxt.valid = 1'b0;
                end
            end
            sdpc_pkg::ST_DOWN: begin
                if (frame_evt && !is_down(frame_mode)) begin
                    core_nxt.st       = sdpc_pkg::ST_WAKE;
                    core_nxt.wake_cnt = core_r.wake_len;
                end
            end
            sdpc_pkg::ST_WAKE: begin
                if (frame_evt && is_down(frame_mode)) begin
                    core_nxt.st = sdpc_pkg::ST_DOWN;
                end else if (core_r.wake_cnt <= 16'h0001) begin
                    core_nxt.st    = sdpc_pkg::ST_RUN;
                    core_nxt.valid = 1'b1;
                end else begin
                    core_nxt.wake_cnt = core_r.wake_cnt - 16'h0001;
                end
            end
            default: begin
                core_nxt.st    = sdpc_pkg::ST_RUN;
                core_nxt.valid = 1'b1;
            end
        endcase

        // analog controls follow the mode of the applied frame
        if (frame_evt) begin
            core_nxt.en        = !is_down(frame_mode);
            core_nxt.amp_conn  = !is_down(frame_mode);
            core_nxt.term_1k   = (frame_mode == 2'h1);
            core_nxt.term_100k = (frame_mode == 2'h2);
        end

        // apb: no wait state, answer prepared in setup
        core_nxt.pready  = 1'b0;
        core_nxt.pslverr = 1'b0;
        if (setup) begin
            core_nxt.pready  = 1'b1;
            core_nxt.pslverr = (sel == 2'h3);
            case (sel)
                2'h0: begin
                    core_nxt.prdata = status;
                end
                2'h1: begin
                    core_nxt.prdata = {16'h0000, core_r.code};
                end
                2'h2: begin
                    core_nxt.prdata = {16'h0000, core_r.wake_len};
                end
                default: begin
                    core_nxt.prdata = 32'h0000_0000;
                end
            endcase
        end

        // write lands at the completing edge of the access phase
        if (PSEL_IN && PENABLE_IN && core_r.pready && PWRITE_IN &&
            (sel == 2'h2)) begin
            // zero is raised to one; with the <= 1 wake check either value ends the wake after one cycle
            core_nxt.wake_len = (PWDATA_IN[15:0] == 16'h0000) ?
                16'h0001 : PWDATA_IN[15:0];
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // power-on: code to zero or midscale, normal mode, everything enabled
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            core_r           <= '0;
            core_r.code      <= CODE_RST;
            core_r.mode      <= sdpc_pkg::MODE_NORMAL;
            core_r.st        <= sdpc_pkg::ST_RUN;
            core_r.wake_len  <= WAKE_RST;
            core_r.valid     <= 1'b1;
            core_r.en        <= 1'b1;
            core_r.amp_conn  <= 1'b1;
        end else begin
            core_r <= core_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign PRDATA_OUT    = core_r.prdata;
    assign PREADY_OUT    = core_r.pready;
    assign PSLVERR_OUT   = core_r.pslverr;
    assign DAC_CODE_OUT  = core_r.code;
    assign MODE_OUT      = core_r.mode;
    assign AMP_CONN_OUT  = core_r.amp_conn;
    assign TERM_1K_OUT   = core_r.term_1k;
    assign TERM_100K_OUT = core_r.term_100k;
    // one enable drives all four blocks together
    assign BIAS_EN_OUT   = core_r.en;
    assign REF_EN_OUT    = core_r.en;
    assign STRING_EN_OUT = core_r.en;
    assign AMP_EN_OUT    = core_r.en;
    assign OUT_VALID_OUT = core_r.valid;

endmodule
